//--- src/lsau_core.sv
`include "lsau_map.svh"
`default_nettype none
// How it works
// - adr writes pc plus signed immediate
// - adr displacement limited to 4095 bytes
// - pc is address plus four, bit1 cleared
// - adr leaves condition flags alone
// - byte, half, word, pair sizes supported
// - unsigned loads zero fill upper bits
// - signed loads sign fill; loads only
// - no offset means base address used
// - offset mode: base plus imm, no writeback
// - pre-index: access and write back sum
// - post-index: access base, write back sum
// - single immediate ranges checked per mode
// - pair immediate multiple of four, 1020
// - second word four bytes higher
// - pc load branches with bit0 cleared
// - loads and stores keep flags
// - register offset shift zero to three
// - address is base plus shifted offset
// - unprivileged forms drive unprivileged attribute
module lsau_core
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    // decode side
    input wire logic req_valid_in,
    output logic req_ready_out,
    input wire lsau_pkg::lsau_op_t op_in,
    input wire lsau_pkg::lsau_size_t size_in,
    input wire lsau_pkg::lsau_mode_t mode_in,
    input wire logic unpriv_in,
    input wire logic privileged_in,
    input wire logic [31:0] pc_in,
    input wire logic [31:0] base_in,
    input wire logic [31:0] offset_reg_in,
    input wire logic [1:0] shift_in,
    input wire logic imm_sub_in,
    input wire logic [12:0] imm_in,
    input wire logic [3:0] xfer_reg_in,
    input wire logic [3:0] xfer2_reg_in,
    input wire logic [31:0] store_data_in,
    input wire logic [31:0] store_data2_in,
    input wire logic [3:0] flags_in,
    // memory bus side
    output logic mem_req_out,
    output logic mem_write_out,
    output logic [31:0] mem_addr_out,
    output logic [3:0] mem_strb_out,
    output logic [31:0] mem_wdata_out,
    output logic mem_priv_out,
    input wire logic mem_done_in,
    input wire logic [31:0] mem_rdata_in,
    // results
    output logic rf_we_out,
    output logic [3:0] rf_addr_out,
    output logic [31:0] rf_data_out,
    output logic base_we_out,
    output logic [31:0] base_data_out,
    output logic branch_out,
    output logic [31:0] branch_addr_out,
    output logic [3:0] flags_out,
    output logic range_err_out
);
    typedef enum logic [1:0]
    {
        LSAU_ST_IDLE,
        LSAU_ST_FIRST,
        LSAU_ST_SECOND
    } lsau_state_t;

    // signed immediate as 32 bits
    function automatic logic [31:0] lsau_simm(input logic sub, input logic [12:0] mag);
        lsau_simm = sub ? (32'h0 - {19'h0, mag}) : {19'h0, mag};
    endfunction : lsau_simm

    lsau_state_t st_q, st_d; // sequencer state
    lsau_pkg::lsau_op_t op_q, op_d; // captured operation
    lsau_pkg::lsau_size_t size_q, size_d; // captured size
    logic [31:0] addr_q, addr_d; // current access address
    logic [31:0] wb_q, wb_d; // pending base writeback
    logic wb_en_q, wb_en_d; // writeback wanted
    logic priv_q, priv_d; // access attribute
    logic [3:0] rt_q, rt_d; // first target
    logic [3:0] rt2_q, rt2_d; // second target
    logic [31:0] sd2_q, sd2_d; // second store word
    logic [31:0] wdat_q, wdat_d; // current store word
    logic rf_we_q, rf_we_d;
    logic [3:0] rf_addr_q, rf_addr_d;
    logic [31:0] rf_data_q, rf_data_d;
    logic base_we_q, base_we_d;
    logic [31:0] base_data_q, base_data_d;
    logic br_q, br_d;
    logic [31:0] br_addr_q, br_addr_d;
    logic err_q, err_d;

    logic [31:0] pc_rel; // aligned pc for pc-relative use
    logic [31:0] sum; // base plus immediate or shifted register
    logic in_range; // immediate legal for this form
    logic [31:0] ext_val; // extended load value
    logic [3:0] lane_strb;
    logic [31:0] lane_data;
    logic is_load;

    // pc bias, bit 1 cleared
    always_comb
    begin
        pc_rel = pc_in + `LSAU_PC_BIAS;
        pc_rel[`LSAU_PC_ALIGN_BIT] = 1'b0;
    end

    // address arithmetic and range checks
    always_comb
    begin
        sum = base_in + lsau_simm(imm_sub_in, imm_in);
        if (mode_in == lsau_pkg::LSAU_AM_REG)
            sum = base_in + (offset_reg_in << shift_in);
        in_range = 1'b1;
        if (op_in == lsau_pkg::LSAU_OP_ADR)
            in_range = imm_in <= `LSAU_ADR_MAX;
        else if (op_in == lsau_pkg::LSAU_OP_LOAD2 || op_in == lsau_pkg::LSAU_OP_STORE2)
            in_range = (imm_in <= `LSAU_DUAL_MAX) && (imm_in[1:0] == 2'h0)
                && (mode_in != lsau_pkg::LSAU_AM_REG);
        else if (mode_in == lsau_pkg::LSAU_AM_OFFSET)
            in_range = imm_sub_in ? (imm_in <= `LSAU_OFS_NEG_MAX)
                : (imm_in <= `LSAU_OFS_POS_MAX);
        else if (mode_in != lsau_pkg::LSAU_AM_REG)
            in_range = imm_in <= `LSAU_IDX_MAX;
        // signed forms are loads only
        if (op_in == lsau_pkg::LSAU_OP_STORE && (size_in == lsau_pkg::LSAU_SZ_SBYTE
            || size_in == lsau_pkg::LSAU_SZ_SHALF))
            in_range = 1'b0;
    end

    lsau_extend u_extend
    (
        .size_in(size_q),
        .addr_lo_in(addr_q[1:0]),
        .rdata_in(mem_rdata_in),
        .value_out(ext_val)
    );

    lsau_lanes u_lanes
    (
        .size_in(size_q),
        .addr_lo_in(addr_q[1:0]),
        .data_in(wdat_q),
        .strb_out(lane_strb),
        .data_out(lane_data)
    );

    assign is_load = (op_q == lsau_pkg::LSAU_OP_LOAD) || (op_q == lsau_pkg::LSAU_OP_LOAD2);
    assign req_ready_out = (st_q == LSAU_ST_IDLE);
    assign mem_req_out = (st_q != LSAU_ST_IDLE);
    assign mem_write_out = (st_q != LSAU_ST_IDLE) && !is_load;
    assign mem_addr_out = addr_q;
    assign mem_strb_out = lane_strb;
    assign mem_wdata_out = lane_data;
    assign mem_priv_out = priv_q;
    assign flags_out = flags_in; // flags pass untouched

    // sequencer next state
    always_comb
    begin
        st_d = st_q;
        op_d = op_q;
        size_d = size_q;
        addr_d = addr_q;
        wb_d = wb_q;
        wb_en_d = wb_en_q;
        priv_d = priv_q;
        rt_d = rt_q;
        rt2_d = rt2_q;
        sd2_d = sd2_q;
        wdat_d = wdat_q;
        rf_we_d = 1'b0;
        rf_addr_d = rf_addr_q;
        rf_data_d = rf_data_q;
        base_we_d = 1'b0;
        base_data_d = base_data_q;
        br_d = 1'b0;
        br_addr_d = br_addr_q;
        err_d = 1'b0;
        case (st_q)
            LSAU_ST_IDLE:
            begin
                if (req_valid_in && op_in != lsau_pkg::LSAU_OP_NONE)
                begin
                    if (!in_range)
                        err_d = 1'b1; // illegal immediate, dropped
                    else if (op_in == lsau_pkg::LSAU_OP_ADR)
                    begin
                        rf_we_d = 1'b1;
                        rf_addr_d = xfer_reg_in;
                        rf_data_d = pc_rel + lsau_simm(imm_sub_in, imm_in);
                    end
                    else
                    begin
                        st_d = LSAU_ST_FIRST;
                        op_d = op_in;
                        // pairs always move words
                        size_d = (op_in == lsau_pkg::LSAU_OP_LOAD2
                            || op_in == lsau_pkg::LSAU_OP_STORE2) ? lsau_pkg::LSAU_SZ_WORD : size_in;
                        addr_d = (mode_in == lsau_pkg::LSAU_AM_POST) ? base_in : sum;
                        wb_d = sum;
                        wb_en_d = (mode_in == lsau_pkg::LSAU_AM_PRE)
                            || (mode_in == lsau_pkg::LSAU_AM_POST);
                        priv_d = privileged_in && !unpriv_in;
                        rt_d = xfer_reg_in;
                        rt2_d = xfer2_reg_in;
                        wdat_d = store_data_in;
                        sd2_d = store_data2_in;
                    end
                end
            end
            LSAU_ST_FIRST, LSAU_ST_SECOND:
            begin
                if (mem_done_in)
                begin
                    if (is_load)
                    begin
                        rf_we_d = 1'b1;
                        rf_addr_d = (st_q == LSAU_ST_SECOND) ? rt2_q : rt_q;
                        rf_data_d = ext_val;
                        // single load of any size into pc is a branch
                        if (st_q == LSAU_ST_FIRST && rt_q == `LSAU_PC_REG
                            && op_q == lsau_pkg::LSAU_OP_LOAD)
                        begin
                            rf_we_d = 1'b0;
                            br_d = 1'b1;
                            br_addr_d = {mem_rdata_in[31:1], 1'b0};
                        end
                    end
                    if (st_q == LSAU_ST_FIRST && (op_q == lsau_pkg::LSAU_OP_LOAD2
                        || op_q == lsau_pkg::LSAU_OP_STORE2))
                    begin
                        st_d = LSAU_ST_SECOND;
                        addr_d = addr_q + `LSAU_DUAL_STEP;
                        wdat_d = sd2_q;
                    end
                    else
                    begin
                        st_d = LSAU_ST_IDLE;
                        base_we_d = wb_en_q;
                        base_data_d = wb_q;
                    end
                end
            end
            default:
                st_d = LSAU_ST_IDLE;
        endcase
    end

    // registers
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            st_q <= LSAU_ST_IDLE;
            op_q <= lsau_pkg::LSAU_OP_NONE;
            size_q <= lsau_pkg::LSAU_SZ_WORD;
            addr_q <= 32'h0000_0000;
            wb_q <= 32'h0000_0000;
            wb_en_q <= 1'b0;
            priv_q <= 1'b0;
            rt_q <= 4'h0;
            rt2_q <= 4'h0;
            sd2_q <= 32'h0000_0000;
            wdat_q <= 32'h0000_0000;
            rf_we_q <= 1'b0;
            rf_addr_q <= 4'h0;
            rf_data_q <= 32'h0000_0000;
            base_we_q <= 1'b0;
            base_data_q <= 32'h0000_0000;
            br_q <= 1'b0;
            br_addr_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            op_q <= op_d;
            size_q <= size_d;
            addr_q <= addr_d;
            wb_q <= wb_d;
            wb_en_q <= wb_en_d;
            priv_q <= priv_d;
            rt_q <= rt_d;
            rt2_q <= rt2_d;
            sd2_q <= sd2_d;
            wdat_q <= wdat_d;
            rf_we_q <= rf_we_d;
            rf_addr_q <= rf_addr_d;
            rf_data_q <= rf_data_d;
            base_we_q <= base_we_d;
            base_data_q <= base_data_d;
            br_q <= br_d;
            br_addr_q <= br_addr_d;
            err_q <= err_d;
        end
    end

    assign rf_we_out = rf_we_q;
    assign rf_addr_out = rf_addr_q;
    assign rf_data_out = rf_data_q;
    assign base_we_out = base_we_q;
    assign base_data_out = base_data_q;
    assign branch_out = br_q;
    assign branch_addr_out = br_addr_q;
    assign range_err_out = err_q;

    // branch target never odd
    pc_branch_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        branch_out |-> (branch_addr_out[0] == 1'b0 && !rf_we_out))
        else $error("pc load branch target odd");
    // flags pass through
    flags_kept_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        flags_out == flags_in)
        else $error("flags changed");
    // second word four above first
    pair_step_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (st_q == LSAU_ST_FIRST && mem_done_in && op_q == lsau_pkg::LSAU_OP_LOAD2)
        |=> (mem_addr_out == $past(mem_addr_out) + 32'h0000_0004))
        else $error("pair address step wrong");
    // unprivileged forms never privileged
    unpriv_attr_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (req_ready_out && req_valid_in && unpriv_in && in_range
        && op_in != lsau_pkg::LSAU_OP_ADR && op_in != lsau_pkg::LSAU_OP_NONE) |=> !mem_priv_out)
        else $error("unprivileged access marked privileged");
    // adr result one cycle later
    adr_result_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (req_ready_out && req_valid_in && op_in == lsau_pkg::LSAU_OP_ADR && in_range)
        |=> (rf_we_out && rf_data_out == (($past(pc_in) + 32'h0000_0004) & 32'hFFFF_FFFD)
        + lsau_simm($past(imm_sub_in), $past(imm_in))))
        else $error("adr result wrong");
    // post index accesses base
    post_addr_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (req_ready_out && req_valid_in && in_range && mode_in == lsau_pkg::LSAU_AM_POST
        && op_in == lsau_pkg::LSAU_OP_LOAD) |=> (mem_addr_out == $past(base_in)))
        else $error("post index address wrong");
    // offset mode never writes base
    offset_nowb_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (req_ready_out && req_valid_in && mode_in == lsau_pkg::LSAU_AM_OFFSET && in_range
        && op_in != lsau_pkg::LSAU_OP_ADR && op_in != lsau_pkg::LSAU_OP_NONE) |=> !wb_en_q)
        else $error("offset mode writes base");
    // out of range adr refused
    adr_range_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (req_ready_out && req_valid_in && op_in == lsau_pkg::LSAU_OP_ADR
        && imm_in > 13'h0FFF) |=> (range_err_out && !rf_we_out))
        else $error("adr range not refused");
endmodule : lsau_core
`default_nettype wire

//--- src/lsau_map.svh
`ifndef LSAU_MAP_SVH
`define LSAU_MAP_SVH
// pc bias and alignment for pc-relative forms
`define LSAU_PC_BIAS 32'h0000_0004
`define LSAU_PC_ALIGN_BIT 1
// immediate range limits, magnitudes
`define LSAU_ADR_MAX 13'h0FFF
`define LSAU_OFS_POS_MAX 13'h0FFF
`define LSAU_OFS_NEG_MAX 13'h00FF
`define LSAU_IDX_MAX 13'h00FF
`define LSAU_DUAL_MAX 13'h03FC
// second word of a pair sits this far above the first
`define LSAU_DUAL_STEP 32'h0000_0004
// largest register-offset shift
`define LSAU_SHIFT_MAX 2'h3
// register index of the program counter
`define LSAU_PC_REG 4'hF
`endif

//--- src/lsau_pkg.sv
`default_nettype none
package lsau_pkg;
    // operation kinds offered by decode
    typedef enum logic [2:0]
    {
        LSAU_OP_NONE,
        LSAU_OP_ADR,
        LSAU_OP_LOAD,
        LSAU_OP_STORE,
        LSAU_OP_LOAD2,
        LSAU_OP_STORE2
    } lsau_op_t;
    // transfer size and signedness
    typedef enum logic [2:0]
    {
        LSAU_SZ_BYTE,
        LSAU_SZ_SBYTE,
        LSAU_SZ_HALF,
        LSAU_SZ_SHALF,
        LSAU_SZ_WORD
    } lsau_size_t;
    // addressing form
    typedef enum logic [1:0]
    {
        LSAU_AM_OFFSET,
        LSAU_AM_PRE,
        LSAU_AM_POST,
        LSAU_AM_REG
    } lsau_mode_t;
endpackage : lsau_pkg
`default_nettype wire

//--- src/lsau_extend.sv
`default_nettype none
// load data extension and lane selection
module lsau_extend
(
    input wire lsau_pkg::lsau_size_t size_in,
    input wire logic [1:0] addr_lo_in,
    input wire logic [31:0] rdata_in,
    output logic [31:0] value_out
);
    logic [7:0] byte_v; // selected byte lane
    logic [15:0] half_v; // selected halfword lane
    // pick the lane the address points at, then extend
    always_comb
    begin
        byte_v = rdata_in[8*addr_lo_in +: 8];
        half_v = addr_lo_in[1] ? rdata_in[31:16] : rdata_in[15:0];
        case (size_in)
            lsau_pkg::LSAU_SZ_BYTE: value_out = {24'h000000, byte_v};
            lsau_pkg::LSAU_SZ_SBYTE: value_out = {{24{byte_v[7]}}, byte_v};
            lsau_pkg::LSAU_SZ_HALF: value_out = {16'h0000, half_v};
            lsau_pkg::LSAU_SZ_SHALF: value_out = {{16{half_v[15]}}, half_v};
            default: value_out = rdata_in;
        endcase
    end
endmodule : lsau_extend
`default_nettype wire

//--- src/lsau_lanes.sv
`default_nettype none
// store byte-lane selects and data replication
module lsau_lanes
(
    input wire lsau_pkg::lsau_size_t size_in,
    input wire logic [1:0] addr_lo_in,
    input wire logic [31:0] data_in,
    output logic [3:0] strb_out,
    output logic [31:0] data_out
);
    // lanes follow size and low address bits
    always_comb
    begin
        case (size_in)
            lsau_pkg::LSAU_SZ_BYTE, lsau_pkg::LSAU_SZ_SBYTE:
            begin
                strb_out = 4'h1 << addr_lo_in;
                data_out = {4{data_in[7:0]}};
            end
            lsau_pkg::LSAU_SZ_HALF, lsau_pkg::LSAU_SZ_SHALF:
            begin
                strb_out = addr_lo_in[1] ? 4'hC : 4'h3;
                data_out = {2{data_in[15:0]}};
            end
            default:
            begin
                strb_out = 4'hF;
                data_out = data_in;
            end
        endcase
    end
endmodule : lsau_lanes
`default_nettype wire

//--- verif/lsau_mem_model.sv
`default_nettype none
// memory bus partner: answers each access after delay_in wait cycles
module lsau_mem_model
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic mem_req_in,
    input wire logic mem_write_in,
    input wire logic [31:0] mem_addr_in,
    input wire logic [3:0] mem_strb_in,
    input wire logic [31:0] mem_wdata_in,
    input wire logic [1:0] delay_in,
    output logic mem_done_out,
    output logic [31:0] mem_rdata_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] words [16]; // aliased by address bits 5:2
    logic [1:0] wait_q; // waits spent on this access
    // read data flips when not answering, so a stale word never looks valid
    always @(posedge clk_in)
    begin
        mem_done_out <= 1'b0;
        mem_rdata_out <= ~mem_rdata_out;
        if (!rst_b_in)
        begin
            wait_q <= 2'h0;
            mem_rdata_out <= 32'hA5A5_5A5A;
        end
        else if (mem_req_in && !mem_done_out)
        begin
            wait_q <= wait_q + 2'h1;
            if (wait_q == delay_in)
            begin
                wait_q <= 2'h0;
                mem_done_out <= 1'b1;
                mem_rdata_out <= words[mem_addr_in[5:2]];
                for (int i = 0; i < 4; i++)
                    if (mem_write_in && mem_strb_in[i])
                        words[mem_addr_in[5:2]][8*i+:8] <= mem_wdata_in[8*i+:8];
            end
        end
    end
endmodule : lsau_mem_model
`default_nettype wire

//--- verif/load_store_address_unit_test.sv
`default_nettype none
module load_store_address_unit_test;
    timeunit 1ns;
    timeprecision 100ps;
    // short aliases for the design's encodings
    localparam lsau_pkg::lsau_op_t o_adr = lsau_pkg::LSAU_OP_ADR, o_ld = lsau_pkg::LSAU_OP_LOAD;
    localparam lsau_pkg::lsau_op_t o_st = lsau_pkg::LSAU_OP_STORE, o_ld2 = lsau_pkg::LSAU_OP_LOAD2;
    localparam lsau_pkg::lsau_op_t o_st2 = lsau_pkg::LSAU_OP_STORE2;
    localparam lsau_pkg::lsau_size_t z_b = lsau_pkg::LSAU_SZ_BYTE, z_sb = lsau_pkg::LSAU_SZ_SBYTE;
    localparam lsau_pkg::lsau_size_t z_h = lsau_pkg::LSAU_SZ_HALF, z_sh = lsau_pkg::LSAU_SZ_SHALF;
    localparam lsau_pkg::lsau_size_t z_w = lsau_pkg::LSAU_SZ_WORD;
    localparam lsau_pkg::lsau_mode_t m_of = lsau_pkg::LSAU_AM_OFFSET, m_pre = lsau_pkg::LSAU_AM_PRE;
    localparam lsau_pkg::lsau_mode_t m_po = lsau_pkg::LSAU_AM_POST, m_rg = lsau_pkg::LSAU_AM_REG;
    logic clk_in = 1'b0, rst_b_in = 1'b0, req_valid_in = 1'b0, unpriv_in = 1'b0;
    logic privileged_in = 1'b1, imm_sub_in = 1'b0, mem_done_in;
    lsau_pkg::lsau_op_t op_in = lsau_pkg::LSAU_OP_NONE;
    lsau_pkg::lsau_size_t size_in = z_w;
    lsau_pkg::lsau_mode_t mode_in = m_of;
    logic [31:0] pc_in = 32'h0, base_in = 32'h0, offset_reg_in = 32'h5, mem_rdata_in;
    logic [31:0] store_data_in = 32'h0000_00C3, store_data2_in = 32'h1E2D_3C4B;
    logic [1:0] shift_in = 2'h0, dly = 2'h0; // dly: partner wait cycles
    logic [12:0] imm_in = 13'h0;
    logic [3:0] xfer_reg_in = 4'h0, xfer2_reg_in = 4'h5, flags_in = 4'h0;
    logic req_ready_out, mem_req_out, mem_write_out, mem_priv_out, rf_we_out, base_we_out;
    logic branch_out, range_err_out;
    logic [31:0] mem_addr_out, mem_wdata_out, rf_data_out, base_data_out, branch_addr_out;
    logic [3:0] mem_strb_out, rf_addr_out, flags_out;
    int error_cnt = 0, checks = 0, cyc = 0, rf_n, bw_n, br_n, re_n, ac_n;
    logic [31:0] rf_d [2], ac_a [2], ac_w [2], bw_d, br_d; // captured results
    logic [3:0] rf_a [2], ac_s [2];
    logic ac_p [2], ac_m [2]; // attribute and write flag per access
    lsau_core dut (.clk_in, .rst_b_in, .req_valid_in, .req_ready_out, .op_in, .size_in,
        .mode_in, .unpriv_in, .privileged_in, .pc_in, .base_in, .offset_reg_in, .shift_in,
        .imm_sub_in, .imm_in, .xfer_reg_in, .xfer2_reg_in, .store_data_in, .store_data2_in,
        .flags_in, .mem_req_out, .mem_write_out, .mem_addr_out, .mem_strb_out,
        .mem_wdata_out, .mem_priv_out, .mem_done_in, .mem_rdata_in, .rf_we_out, .rf_addr_out,
        .rf_data_out, .base_we_out, .base_data_out, .branch_out, .branch_addr_out,
        .flags_out, .range_err_out);
    lsau_mem_model mem_u (.clk_in, .rst_b_in, .mem_req_in(mem_req_out),
        .mem_write_in(mem_write_out), .mem_addr_in(mem_addr_out), .mem_strb_in(mem_strb_out),
        .mem_wdata_in(mem_wdata_out), .delay_in(dly), .mem_done_out(mem_done_in),
        .mem_rdata_out(mem_rdata_in));
    always #5 clk_in = ~clk_in;
    // closing report, also reached by the cycle ceiling
    task automatic end_of_test();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask : chk
    // monitor: logs result pulses and completed bus accesses at each edge
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            end_of_test();
        end
        if (rf_we_out === 1'b1)
            {rf_a[rf_n%2], rf_d[rf_n%2], rf_n} = {rf_addr_out, rf_data_out, rf_n + 1};
        if (base_we_out === 1'b1)
            {bw_d, bw_n} = {base_data_out, bw_n + 1};
        if (branch_out === 1'b1)
            {br_d, br_n} = {branch_addr_out, br_n + 1};
        if (range_err_out === 1'b1)
            re_n++;
        if (mem_done_in && mem_req_out === 1'b1)
        begin
            {ac_a[ac_n%2], ac_w[ac_n%2], ac_s[ac_n%2]} = {mem_addr_out, mem_wdata_out, mem_strb_out};
            {ac_p[ac_n%2], ac_m[ac_n%2]} = {mem_priv_out, mem_write_out};
            ac_n++;
        end
    end
    // one request, held for its taking edge, then wait for idle under a bound
    task automatic run(input lsau_pkg::lsau_op_t o, input lsau_pkg::lsau_size_t s,
        input lsau_pkg::lsau_mode_t m, input logic sb, input logic [12:0] im,
        input logic [31:0] b, input logic [3:0] x);
        int n;
        {rf_n, bw_n, br_n, re_n, ac_n, n} = '0;
        {op_in, size_in, mode_in, imm_sub_in, imm_in, base_in, xfer_reg_in} = {o, s, m, sb, im, b, x};
        req_valid_in = 1'b1;
        @(posedge clk_in);
        #1 req_valid_in = 1'b0;
        do
        begin
            @(posedge clk_in);
            #1 n++;
        end
        while (!(req_ready_out === 1'b1 && n > 1) && n < 40);
        // a request that never finishes counts as a mismatch
        if (req_ready_out !== 1'b1)
        begin
            $display("[FAIL] run_idle expected 1 seen %b", req_ready_out);
            error_cnt++;
        end
        repeat (2) @(posedge clk_in);
        #1;
    endtask : run
    task automatic t_adr();
        pc_in = 32'h0000_1006; // aligned pc is 0x1008
        flags_in = 4'hA;
        run(o_adr, z_w, m_of, 1'b0, 13'h0FFF, 32'h0, 4'h3);
        chk("adr_add", 32'h0000_2007, rf_d[0]);
        chk("adr_dst", 4'h3, rf_a[0]);
        chk("adr_flags", 4'hA, flags_out);
        run(o_adr, z_w, m_of, 1'b1, 13'h0FFF, 32'h0, 4'h3);
        chk("adr_sub", 32'h0000_0009, rf_d[0]);
        run(o_adr, z_w, m_of, 1'b0, 13'h1000, 32'h0, 4'h3);
        chk("adr_refuse", 1, re_n);
        chk("adr_nowr", 0, rf_n);
    endtask : t_adr
    // every size, zero offset so the base itself is the address
    task automatic t_ext();
        lsau_pkg::lsau_size_t sz [6] = '{z_b, z_sb, z_sb, z_h, z_sh, z_w};
        logic [31:0] ad [6] = '{32'h5, 32'h7, 32'h5, 32'h6, 32'h6, 32'h4};
        logic [31:0] ex [6] = '{32'h7E, 32'hFFFF_FFF0, 32'h7E, 32'hF08C, 32'hFFFF_F08C,
            32'hF08C_7E91};
        mem_u.words[1] = 32'hF08C_7E91;
        for (int i = 0; i < 6; i++)
        begin
            run(o_ld, sz[i], m_of, 1'b0, 13'h0, ad[i], 4'h2);
            chk("ld_addr", ad[i], ac_a[0]);
            chk("ld_wr", 0, ac_m[0]);
            chk("ld_val", ex[i], rf_d[0]);
        end
    endtask : t_ext
    // offset, pre and post indexing at the edges of their ranges, slow partner
    task automatic t_modes();
        lsau_pkg::lsau_mode_t md [7] = '{m_of, m_of, m_pre, m_po, m_pre, m_po, m_of};
        logic sb [7] = '{1, 0, 0, 1, 0, 0, 1};
        logic [12:0] im [7] = '{13'hFF, 13'hFFF, 13'hFF, 13'hFF, 13'h100, 13'h100, 13'h100};
        logic [31:0] ea [7] = '{32'h101, 32'h11FF, 32'h2FF, 32'h200, 0, 0, 0};
        logic [31:0] ew [7] = '{0, 0, 32'h2FF, 32'h101, 0, 0, 0};
        dly = 2'h2;
        for (int i = 0; i < 7; i++)
        begin
            run(o_ld, z_w, md[i], sb[i], im[i], 32'h200, 4'h1);
            chk("m_refuse", i > 3, re_n);
            chk("m_acc", i < 4, ac_n);
            if (i < 4)
                chk("m_addr", ea[i], ac_a[0]);
            chk("m_wbn", ew[i] != 0, bw_n);
            if (ew[i] != 0)
                chk("m_wb", ew[i], bw_d);
        end
        dly = 2'h0;
    endtask : t_modes
    task automatic t_pair();
        mem_u.words[3] = 32'h1357_9BDF;
        mem_u.words[4] = 32'h2468_ACE0;
        run(o_ld2, z_w, m_of, 1'b0, 13'h03FC, 32'h10, 4'h4);
        chk("p_n", 2, ac_n);
        chk("p_a1", 32'h410, ac_a[1]);
        chk("p_d0", 32'h1357_9BDF, rf_d[0]);
        chk("p_r1", 4'h5, rf_a[1]);
        chk("p_d1", 32'h2468_ACE0, rf_d[1]);
        run(o_st2, z_w, m_pre, 1'b1, 13'h03FC, 32'h800, 4'h4);
        chk("ps_a0", 32'h404, ac_a[0]);
        chk("ps_w1", 32'h1E2D_3C4B, ac_w[1]);
        chk("ps_wb", 32'h404, bw_d);
        run(o_ld2, z_w, m_of, 1'b0, 13'h03FE, 32'h10, 4'h4);
        chk("p_odd", 1, re_n);
        run(o_st2, z_w, m_po, 1'b0, 13'h0400, 32'h10, 4'h4);
        chk("p_big", 1, re_n);
    endtask : t_pair
    task automatic t_pc();
        mem_u.words[2] = 32'h0000_2469; // loaded target has bit 0 set
        flags_in = 4'h5;
        run(o_ld, z_w, m_of, 1'b0, 13'h0, 32'h8, 4'hF);
        chk("pc_br", 1, br_n);
        chk("pc_tgt", 32'h0000_2468, br_d);
        chk("pc_norf", 0, rf_n);
        chk("pc_flags", 4'h5, flags_out);
    endtask : t_pc
    // shifted register offset; odd passes use the unprivileged form
    task automatic t_reg();
        for (int s = 0; s < 4; s++)
        begin
            {shift_in, unpriv_in} = {s[1:0], s[0]};
            run(o_ld, z_w, m_rg, 1'b0, 13'h0, 32'h100, 4'h1);
            chk("r_addr", 32'h100 + (32'h5 << s), ac_a[0]);
            chk("r_priv", !s[0], ac_p[0]);
        end
        unpriv_in = 1'b0;
    endtask : t_reg
    // byte lanes follow size and low address bits
    task automatic t_strb();
        lsau_pkg::lsau_size_t sz [7] = '{z_b, z_b, z_b, z_b, z_h, z_h, z_w};
        logic [31:0] ad [7] = '{32'h20, 32'h21, 32'h22, 32'h23, 32'h20, 32'h22, 32'h20};
        logic [3:0] sb [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};
        for (int i = 0; i < 7; i++)
        begin
            run(o_st, sz[i], m_of, 1'b0, 13'h0, ad[i], 4'h6);
            chk("s_strb", sb[i], ac_s[0]);
            chk("s_wr", 1, ac_m[0]);
            chk("s_lane", 8'hC3, ac_w[0][8*ad[i][1:0]+:8]);
        end
        run(o_st, z_sb, m_of, 1'b0, 13'h0, 32'h20, 4'h6);
        chk("s_signed", 1, re_n);
        chk("s_noacc", 0, ac_n);
    endtask : t_strb
    initial
    begin
        repeat (20) @(posedge clk_in);
        #1 rst_b_in = 1'b1;
        t_adr();
        t_ext();
        t_modes();
        t_pair();
        t_pc();
        t_reg();
        t_strb();
        end_of_test();
    end
endmodule : load_store_address_unit_test
`default_nettype wire
